// ---- include/hca_pkg.sv ----
// Purpose: constants and carrier types of the heater current alarm
// Assumes: 40 MHz ref_clk; currents coded in 0.1 A steps
// Notes:   register offsets are byte addresses of aligned words
`default_nettype none
package hca_pkg;
	// ---------------------------------------------------------------
	// current coding and threshold limits
	// ---------------------------------------------------------------
	localparam int              CUR_W   = 9;
	localparam int              MAX_CT  = 2;
	localparam logic [CUR_W-1:0] THR_MIN = 9'h001;  // 0.1 A
	localparam logic [CUR_W-1:0] THR_MAX = 9'h1F3;  // 49.9 A
	localparam logic [CUR_W-1:0] THR_RST = 9'h001;

	// ---------------------------------------------------------------
	// timing: times in ms, cycle counts derived from the clock rate
	// ---------------------------------------------------------------
	localparam int CLK_KHZ          = 40000;
	localparam int MIN_ON_MS        = 100;
	localparam int MIN_ON_SHORT_MS  = 30;
	localparam int MIN_OFF_MS       = 100;
	localparam int MIN_OFF_SHORT_MS = 35;
	localparam int MIN_ON_CYC        = MIN_ON_MS * CLK_KHZ;
	localparam int MIN_ON_SHORT_CYC  = MIN_ON_SHORT_MS * CLK_KHZ;
	localparam int MIN_OFF_CYC       = MIN_OFF_MS * CLK_KHZ;
	localparam int MIN_OFF_SHORT_CYC = MIN_OFF_SHORT_MS * CLK_KHZ;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam int         ADDR_W     = 8;
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_HB_THR = 8'h04;
	localparam logic [7:0] OFS_SW_THR = 8'h08;
	localparam logic [7:0] OFS_ALARM  = 8'h0C;
	localparam logic [7:0] OFS_ISTAT  = 8'h10;
	localparam logic [7:0] OFS_IMASK  = 8'h14;
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_SHORT_BIT = 1;
	localparam int CTRL_3PH_BIT   = 2;
	localparam int IRQ_HB_BIT     = 0;
	localparam int IRQ_SW_BIT     = 1;
	localparam int ALARM_SW_LSB   = 2;     // hb bits at [1:0]
	localparam logic [1:0] IRQ_RST = 2'h0;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic             enable;
		logic             short_period;
		logic             three_phase;
		logic [CUR_W-1:0] hb_thr;
		logic [CUR_W-1:0] sw_thr;
	} hca_cfg_t;

	typedef struct packed {
		logic hb;
		logic sw;
	} hca_alarm_t;

	typedef enum logic [1:0] {
		EV_IDLE  = 2'b00,
		EV_WAIT  = 2'b01,
		EV_READY = 2'b10
	} hca_ev_state_t;
endpackage
`default_nettype wire

// ---- tb/hca_ct_model.sv ----
// Purpose: current sense partner for the heater alarm bench
// Assumes: one sample per request, taken on ref_clk
// Notes:   between strobes the line flips every cycle, last sample and its inverse in turn
`default_nettype none
module hca_ct_model (
	input  wire logic        ref_clk,   // system clock
	input  wire logic        resetn,    // sync reset, active low
	input  wire logic        smp_req,   // take one sample
	input  wire logic [17:0] load_cur,  // heater current, both channels
	output logic             cur_valid, // one-cycle sample strobe
	output logic [17:0]      cur_sense  // sensed currents, 0.1 A units
);
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------
	// sampling
	// ---------------------------------------------------------------
	// stale data is flipped so a late read cannot pass by luck
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cur_valid <= 1'b0;
			cur_sense <= 18'h00000;
		end else if (smp_req) begin
			cur_valid <= 1'b1;
			cur_sense <= load_cur;
		end else begin
			cur_valid <= 1'b0;
			cur_sense <= ~cur_sense;
		end
	end
endmodule
`default_nettype wire

// ---- tb/hca_tb_top.sv ----
// Purpose: self-checking bench of the heater current alarm block
// Assumes: shortened qualifying counts of 20/6/20/7 cycles
// Notes:   apb master waits on pready; a cycle ceiling cuts hangs
`default_nettype none
module hca_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic        ctrl_out, smp_req, cur_valid, burnout_alarm, ssw_fail;
	logic        irq, err;
	logic [7:0]  paddr, thr_ofs;
	logic [31:0] pwdata, prdata, rd;
	logic [17:0] load_cur, cur_sense;
	int          err_total, num_checks, cyc;

	// ---------------------------------------------------------------
	// design and partner
	// ---------------------------------------------------------------
	hca_top #(.MIN_ON_CYC(20), .MIN_ON_SH_CYC(6), .MIN_OFF_CYC(20),
		.MIN_OFF_SH_CYC(7)) uut (.ref_clk(ref_clk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ctrl_out(ctrl_out), .cur_valid(cur_valid),
		.current_sense_input(cur_sense), .burnout_alarm(burnout_alarm),
		.solid_state_switch_fail(ssw_fail), .irq(irq));
	hca_ct_model ct (.ref_clk(ref_clk), .resetn(resetn), .smp_req(smp_req),
		.load_cur(load_cur), .cur_valid(cur_valid), .cur_sense(cur_sense));

	// clock and hang guard, ceiling well above the ~300 cycles needed
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			finish_test();
		end
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s seen %h exp %h",
				$time, what, seen, exp);
		end
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// one apb transfer; request held until pready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] e, input string w);
		apb(1'b0, a, 32'h00000000);
		check(rd, e, w);
	endtask

	task chk_irq(input logic e, input string w);
		wait_cyc(2);
		check({31'h0, irq}, {31'h0, e}, w);
	endtask

	// one sample, then pins and alarm register against {sw1,sw0,hb1,hb0}
	task smp(input logic [17:0] cur, input logic [3:0] e, input string w);
		@(posedge ref_clk);
		smp_req <= 1'b1;
		load_cur <= cur;
		@(posedge ref_clk);
		smp_req <= 1'b0;
		wait_cyc(5);
		check({30'h0, ssw_fail, burnout_alarm}, {30'h0, |e[3:2], |e[1:0]}, w);
		rd_chk(hca_pkg::OFS_ALARM, {28'h0, e}, w);
	endtask

	task set_ctrl(input logic lvl, input int n);
		@(posedge ref_clk);
		ctrl_out <= lvl;
		wait_cyc(n);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		resetn = 1'b0;
		{psel, penable, pwrite, ctrl_out, smp_req} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		load_cur = 18'h00000;
		wait_cyc(2);
		resetn <= 1'b1;
		// reset values and an unmapped place
		rd_chk(hca_pkg::OFS_CTRL, 32'h0, "ctrl reset");
		rd_chk(hca_pkg::OFS_HB_THR, 32'h1, "hb thr reset");
		rd_chk(hca_pkg::OFS_SW_THR, 32'h1, "sw thr reset");
		rd_chk(hca_pkg::OFS_ISTAT, 32'h0, "istat reset");
		rd_chk(hca_pkg::OFS_IMASK, 32'h0, "imask reset");
		rd_chk(8'h18, 32'h0, "unmapped data");
		check({31'h0, err}, 32'h1, "unmapped error");
		apb(1'b1, 8'h18, 32'h00000007);
		check({31'h0, err}, 32'h1, "unmapped write error");
		rd_chk(hca_pkg::OFS_CTRL, 32'h0, "ctrl after unmapped");
		// threshold bounds: ends kept, outside values ignored
		for (int i = 0; i < 2; i++) begin
			thr_ofs = i ? hca_pkg::OFS_SW_THR : hca_pkg::OFS_HB_THR;
			apb(1'b1, thr_ofs, 32'h1F3);
			rd_chk(thr_ofs, 32'h1F3, "thr max");
			apb(1'b1, thr_ofs, 32'h1F4);
			rd_chk(thr_ofs, 32'h1F3, "thr above");
			apb(1'b1, thr_ofs, 32'h0);
			rd_chk(thr_ofs, 32'h1F3, "thr zero");
			apb(1'b1, thr_ofs, 32'h1);
			rd_chk(thr_ofs, 32'h1, "thr min");
		end
		// both channels, 10.0 A burnout limit, 2.0 A switch limit
		apb(1'b1, hca_pkg::OFS_HB_THR, 32'h64);
		apb(1'b1, hca_pkg::OFS_SW_THR, 32'h14);
		apb(1'b1, hca_pkg::OFS_IMASK, 32'h3);
		apb(1'b1, hca_pkg::OFS_CTRL, 32'h5);
		// heater on, normal period
		set_ctrl(1'b1, 8);
		smp({9'd50, 9'd50}, 4'h0, "early on sample");
		wait_cyc(20);
		smp({9'd150, 9'd99}, 4'h1, "burnout ch0");
		chk_irq(1'b1, "irq on burnout");
		apb(1'b1, hca_pkg::OFS_ISTAT, 32'h1);
		chk_irq(1'b0, "irq after clear");
		smp({9'd99, 9'd100}, 4'h2, "ch1 low, ch0 at limit");
		smp({9'd100, 9'd100}, 4'h0, "burnout cleared");
		// heater off, normal period
		set_ctrl(1'b0, 8);
		smp({9'd30, 9'd30}, 4'h0, "early off sample");
		wait_cyc(20);
		smp({9'd0, 9'd21}, 4'h4, "switch fail ch0");
		smp({9'd0, 9'd20}, 4'h0, "switch at limit");
		apb(1'b1, hca_pkg::OFS_ISTAT, 32'h3);
		// short period, interrupt masked first
		apb(1'b1, hca_pkg::OFS_IMASK, 32'h0);
		apb(1'b1, hca_pkg::OFS_CTRL, 32'h7);
		set_ctrl(1'b1, 8);
		smp({9'd100, 9'd10}, 4'h1, "short on");
		chk_irq(1'b0, "irq masked");
		rd_chk(hca_pkg::OFS_ISTAT, 32'h1, "istat while masked");
		apb(1'b1, hca_pkg::OFS_IMASK, 32'h3);
		chk_irq(1'b1, "irq unmasked");
		apb(1'b1, hca_pkg::OFS_ISTAT, 32'h1);
		chk_irq(1'b0, "irq cleared");
		// burnout of ch0 holds through the off interval
		set_ctrl(1'b0, 8);
		smp({9'd0, 9'd40}, 4'h5, "short off");
		// channel 1 drops out in single-phase mode
		apb(1'b1, hca_pkg::OFS_CTRL, 32'h3);
		smp({9'd40, 9'd0}, 4'h1, "single phase");
		apb(1'b1, hca_pkg::OFS_CTRL, 32'h0);
		wait_cyc(3);
		check({30'h0, ssw_fail, burnout_alarm}, 32'h0, "disabled");
		finish_test();
	end
endmodule
`default_nettype wire

// ---- verilog/hca_eval.sv ----
// Purpose: per-channel burnout and switch failure evaluation
// Assumes: ctrl_on and samples come from logic on ref_clk
// Notes:   a sample only counts once the interval is long enough
`default_nettype none
module hca_eval #(
	parameter int CNT_W = 23
) (
	input  wire logic                     ref_clk,   // system clock
	input  wire logic                     resetn,    // sync reset
	input  wire logic                     en,        // channel active
	input  wire logic                     ctrl_on,   // control output
	input  wire logic                     smp_valid, // new sample
	input  wire logic [hca_pkg::CUR_W-1:0] cur,      // 0.1 A units
	input  wire logic [hca_pkg::CUR_W-1:0] hb_thr,   // burnout limit
	input  wire logic [hca_pkg::CUR_W-1:0] sw_thr,   // switch limit
	input  wire logic [CNT_W-1:0]         min_on,    // on cycles
	input  wire logic [CNT_W-1:0]         min_off,   // off cycles
	output var hca_pkg::hca_alarm_t       alarm,     // alarm levels
	output var hca_pkg::hca_alarm_t       rise       // alarm set pulse
);
	// ---------------------------------------------------------------
	// interval qualification and evaluation
	// ---------------------------------------------------------------
	hca_pkg::hca_ev_state_t state;
	hca_pkg::hca_ev_state_t next_state;
	logic [CNT_W-1:0]       cnt;
	logic [CNT_W-1:0]       next_cnt;
	logic                   prev_on;
	hca_pkg::hca_alarm_t    next_alarm;
	hca_pkg::hca_alarm_t    next_rise;
	logic                   steady;
	logic                   eval_on;
	logic                   eval_off;

	// an edge of the control output restarts the interval
	assign steady   = en && (ctrl_on == prev_on) &&
	                  (state == hca_pkg::EV_READY);
	assign eval_on  = steady && prev_on && smp_valid;
	assign eval_off = steady && !prev_on && smp_valid;

	// next interval state, counter and alarm levels
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_alarm = alarm;
		if (!en) begin
			next_state = hca_pkg::EV_IDLE;
			next_cnt   = '0;
			next_alarm = '0;
		end else if (state == hca_pkg::EV_IDLE || ctrl_on != prev_on) begin
			next_state = hca_pkg::EV_WAIT;
			next_cnt   = '0;
		end else begin
			case (state)
			hca_pkg::EV_WAIT: begin
				next_cnt = cnt + 1'b1;
				if (next_cnt >= (prev_on ? min_on : min_off)) begin
					next_state = hca_pkg::EV_READY;
				end
			end
			hca_pkg::EV_READY: begin
				// same 0.1 A coding on both sides of the compare
				if (eval_on) begin
					next_alarm.hb = (cur < hb_thr);
				end
				if (eval_off) begin
					next_alarm.sw = (cur > sw_thr);
				end
			end
			default: begin
				next_state = hca_pkg::EV_IDLE;
			end
			endcase
		end
		next_rise.hb = next_alarm.hb && !alarm.hb;
		next_rise.sw = next_alarm.sw && !alarm.sw;
	end

	// registers only
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state   <= hca_pkg::EV_IDLE;
			cnt     <= '0;
			prev_on <= 1'b0;
			alarm   <= '0;
			rise    <= '0;
		end else begin
			state   <= next_state;
			cnt     <= next_cnt;
			prev_on <= ctrl_on;
			alarm   <= next_alarm;
			rise    <= next_rise;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	chk_hb_needs_on: assert property (
		eval_on |-> ctrl_on && $past(ctrl_on))
		else $error("burnout evaluated with control off");
	chk_sw_needs_off: assert property (
		eval_off |-> !ctrl_on && !$past(ctrl_on))
		else $error("switch evaluated with control on");
	chk_hb_low_sets: assert property (
		eval_on && (cur < hb_thr) |=> alarm.hb)
		else $error("low on-current did not raise burnout");
	chk_sw_high_sets: assert property (
		eval_off && (cur > sw_thr) |=> alarm.sw)
		else $error("high off-current did not raise switch alarm");
	chk_alarm_clears: assert property (
		eval_on && (cur >= hb_thr) |=> !alarm.hb)
		else $error("burnout held after good measurement");
	chk_on_interval: assert property (
		eval_on |-> cnt >= min_on)
		else $error("burnout evaluated before minimum on time");
	chk_off_interval: assert property (
		eval_off |-> cnt >= min_off)
		else $error("switch evaluated before minimum off time");
	chk_edge_restarts: assert property (
		en && (ctrl_on != prev_on)
		|=> state == hca_pkg::EV_WAIT && cnt == '0)
		else $error("control edge did not restart interval");
endmodule
`default_nettype wire

// ---- verilog/hca_top.sv ----
// Purpose: heater burnout and switch failure alarm with APB registers
// Assumes: samples and control output come from logic on ref_clk
// Notes:   no wait state on any APB access
`default_nettype none
module hca_top #(
	parameter int NUM_CT          = 2,
	parameter int CNT_W           = 23,
	parameter int MIN_ON_CYC      = hca_pkg::MIN_ON_CYC,
	parameter int MIN_ON_SH_CYC   = hca_pkg::MIN_ON_SHORT_CYC,
	parameter int MIN_OFF_CYC     = hca_pkg::MIN_OFF_CYC,
	parameter int MIN_OFF_SH_CYC  = hca_pkg::MIN_OFF_SHORT_CYC
) (
	input  wire logic                  ref_clk,   // 40 MHz clock
	input  wire logic                  resetn,    // sync, active low
	input  wire logic                  psel,      // apb select
	input  wire logic                  penable,   // apb enable
	input  wire logic                  pwrite,    // apb direction
	input  wire logic [hca_pkg::ADDR_W-1:0] paddr, // apb byte address
	input  wire logic [31:0]           pwdata,    // apb write data
	output logic [31:0]                prdata,    // apb read data
	output logic                       pready,    // apb ready
	output logic                       pslverr,   // unmapped address
	input  wire logic                  ctrl_out,  // control output level
	input  wire logic                  cur_valid, // sample strobe
	input  wire logic [NUM_CT*hca_pkg::CUR_W-1:0] current_sense_input,
	output logic                       burnout_alarm,         // any ch
	output logic                       solid_state_switch_fail, // any ch
	output logic                       irq        // level interrupt
);
	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == hca_pkg::OFS_CTRL)   || (a == hca_pkg::OFS_HB_THR) ||
		          (a == hca_pkg::OFS_SW_THR) || (a == hca_pkg::OFS_ALARM)  ||
		          (a == hca_pkg::OFS_ISTAT)  || (a == hca_pkg::OFS_IMASK);
	endfunction

	// out-of-range writes are dropped so the limit always stays legal
	function automatic logic thr_ok(input logic [31:0] d);
		thr_ok = (d[31:hca_pkg::CUR_W] == '0) &&
		         (d[hca_pkg::CUR_W-1:0] >= hca_pkg::THR_MIN) &&
		         (d[hca_pkg::CUR_W-1:0] <= hca_pkg::THR_MAX);
	endfunction

	// ---------------------------------------------------------------
	// channels
	// ---------------------------------------------------------------
	hca_pkg::hca_cfg_t   cfg;
	hca_pkg::hca_cfg_t   next_cfg;
	hca_pkg::hca_alarm_t ch_alarm [hca_pkg::MAX_CT];
	hca_pkg::hca_alarm_t ch_rise  [hca_pkg::MAX_CT];
	logic [hca_pkg::MAX_CT-1:0] hb_vec;
	logic [hca_pkg::MAX_CT-1:0] sw_vec;
	logic [hca_pkg::MAX_CT-1:0] hb_rise_vec;
	logic [hca_pkg::MAX_CT-1:0] sw_rise_vec;
	logic [CNT_W-1:0]     min_on;
	logic [CNT_W-1:0]     min_off;

	// short control periods shorten both qualifying intervals
	assign min_on  = cfg.short_period ? CNT_W'(MIN_ON_SH_CYC)
	                                  : CNT_W'(MIN_ON_CYC);
	assign min_off = cfg.short_period ? CNT_W'(MIN_OFF_SH_CYC)
	                                  : CNT_W'(MIN_OFF_CYC);

	// one evaluator per fitted input, unfitted slots read as quiet
	genvar gi;
	generate
		for (gi = 0; gi < hca_pkg::MAX_CT; gi++) begin : g_ch
			if (gi < NUM_CT) begin : g_fit
				hca_eval #(
					.CNT_W     (CNT_W)
				) u_eval (
					.ref_clk   (ref_clk),
					.resetn    (resetn),
					// second input only serves three-phase loads
					.en        (cfg.enable && (gi == 0 || cfg.three_phase)),
					.ctrl_on   (ctrl_out),
					.smp_valid (cur_valid),
					.cur       (current_sense_input[gi*hca_pkg::CUR_W +:
					                                hca_pkg::CUR_W]),
					.hb_thr    (cfg.hb_thr),
					.sw_thr    (cfg.sw_thr),
					.min_on    (min_on),
					.min_off   (min_off),
					.alarm     (ch_alarm[gi]),
					.rise      (ch_rise[gi])
				);
			end else begin : g_none
				assign ch_alarm[gi] = '0;
				assign ch_rise[gi]  = '0;
			end
			assign hb_vec[gi]      = ch_alarm[gi].hb;
			assign sw_vec[gi]      = ch_alarm[gi].sw;
			assign hb_rise_vec[gi] = ch_rise[gi].hb;
			assign sw_rise_vec[gi] = ch_rise[gi].sw;
		end
	endgenerate

	// ---------------------------------------------------------------
	// apb slave, interrupt and outputs
	// ---------------------------------------------------------------
	logic [1:0]  istat;
	logic [1:0]  next_istat;
	logic [1:0]  imask;
	logic [1:0]  next_imask;
	logic [1:0]  ev;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic        setup;
	logic        wr;

	assign setup = psel && !penable;
	assign wr    = psel && penable && pwrite && pready && addr_ok(paddr);
	assign ev    = {|sw_rise_vec, |hb_rise_vec};

	// ready is raised in the setup cycle so every access takes two edges
	always_comb begin
		next_cfg     = cfg;
		next_imask   = imask;
		next_istat   = istat | ev;   // a new event beats the clear below
		next_pready  = setup;
		next_pslverr = setup && !addr_ok(paddr);
		next_prdata  = prdata;
		if (setup && !pwrite) begin
			next_prdata = 32'h0000_0000;
			case (paddr)
			hca_pkg::OFS_CTRL: begin
				next_prdata[hca_pkg::CTRL_EN_BIT]    = cfg.enable;
				next_prdata[hca_pkg::CTRL_SHORT_BIT] = cfg.short_period;
				next_prdata[hca_pkg::CTRL_3PH_BIT]   = cfg.three_phase;
			end
			hca_pkg::OFS_HB_THR: begin
				next_prdata[hca_pkg::CUR_W-1:0] = cfg.hb_thr;
			end
			hca_pkg::OFS_SW_THR: begin
				next_prdata[hca_pkg::CUR_W-1:0] = cfg.sw_thr;
			end
			hca_pkg::OFS_ALARM: begin
				next_prdata[hca_pkg::MAX_CT-1:0] = hb_vec;
				next_prdata[hca_pkg::ALARM_SW_LSB +: hca_pkg::MAX_CT] = sw_vec;
			end
			hca_pkg::OFS_ISTAT: begin
				next_prdata[1:0] = istat;
			end
			hca_pkg::OFS_IMASK: begin
				next_prdata[1:0] = imask;
			end
			default: begin
				next_prdata = 32'h0000_0000;
			end
			endcase
		end
		if (wr) begin
			case (paddr)
			hca_pkg::OFS_CTRL: begin
				next_cfg.enable       = pwdata[hca_pkg::CTRL_EN_BIT];
				next_cfg.short_period = pwdata[hca_pkg::CTRL_SHORT_BIT];
				next_cfg.three_phase  = pwdata[hca_pkg::CTRL_3PH_BIT];
			end
			hca_pkg::OFS_HB_THR: begin
				if (thr_ok(pwdata)) begin
					next_cfg.hb_thr = pwdata[hca_pkg::CUR_W-1:0];
				end
			end
			hca_pkg::OFS_SW_THR: begin
				if (thr_ok(pwdata)) begin
					next_cfg.sw_thr = pwdata[hca_pkg::CUR_W-1:0];
				end
			end
			hca_pkg::OFS_ISTAT: begin
				next_istat = (istat & ~pwdata[1:0]) | ev;
			end
			hca_pkg::OFS_IMASK: begin
				next_imask = pwdata[1:0];
			end
			default: begin
				next_cfg = cfg;
			end
			endcase
		end
	end

	// registers only; outputs all leave from here
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cfg <= '{enable: 1'b0, short_period: 1'b0, three_phase: 1'b0,
			         hb_thr: hca_pkg::THR_RST, sw_thr: hca_pkg::THR_RST};
			istat                   <= hca_pkg::IRQ_RST;
			imask                   <= hca_pkg::IRQ_RST;
			prdata                  <= 32'h0000_0000;
			pready                  <= 1'b0;
			pslverr                 <= 1'b0;
			irq                     <= 1'b0;
			burnout_alarm           <= 1'b0;
			solid_state_switch_fail <= 1'b0;
		end else begin
			cfg                     <= next_cfg;
			istat                   <= next_istat;
			imask                   <= next_imask;
			prdata                  <= next_prdata;
			pready                  <= next_pready;
			pslverr                 <= next_pslverr;
			irq                     <= |(next_istat & next_imask);
			burnout_alarm           <= |hb_vec;
			solid_state_switch_fail <= |sw_vec;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_hb_thr_range: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		cfg.hb_thr >= hca_pkg::THR_MIN && cfg.hb_thr <= hca_pkg::THR_MAX)
		else $error("burnout threshold out of range");
	chk_sw_thr_range: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		cfg.sw_thr >= hca_pkg::THR_MIN && cfg.sw_thr <= hca_pkg::THR_MAX)
		else $error("switch threshold out of range");
	chk_alarm_follow: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		$rose(hb_vec[0]) |=> burnout_alarm)
		else $error("burnout pin did not follow channel");
	chk_single_quiet: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		// a dropped channel clears one edge after the mode change
		(!$past(cfg.three_phase) || !$past(cfg.enable))
		|-> !hb_vec[1] && !sw_vec[1])
		else $error("second input active without three-phase mode");
	chk_short_min: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		cfg.short_period |-> min_on == CNT_W'(MIN_ON_SH_CYC)
		                  && min_off == CNT_W'(MIN_OFF_SH_CYC))
		else $error("short period minimum not selected");
	chk_irq_level: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		##1 irq == |(istat & imask))
		else $error("interrupt does not match masked status");
	// no wait state: ready answers a setup and nothing else
	chk_ready_setup: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_cause: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		pready |-> $past(psel) && !$past(penable))
		else $error("ready without setup");
	chk_err_ready: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		pslverr |-> pready)
		else $error("error without ready");
	chk_err_unmapped: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		psel && !penable && !addr_ok(paddr) |=> pslverr)
		else $error("unmapped address not flagged");
	chk_rd_unmapped: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		psel && !penable && !pwrite && !addr_ok(paddr)
		|=> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_wr_unmapped: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		psel && penable && !addr_ok(paddr)
		|=> $stable(cfg) && $stable(imask))
		else $error("unmapped write landed");
	chk_ctrl_write: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		wr && paddr == hca_pkg::OFS_CTRL
		|=> cfg.enable == $past(pwdata[hca_pkg::CTRL_EN_BIT])
		 && cfg.three_phase == $past(pwdata[hca_pkg::CTRL_3PH_BIT]))
		else $error("control bits not written");
	chk_mask_write: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		wr && paddr == hca_pkg::OFS_IMASK
		|=> imask == $past(pwdata[1:0]))
		else $error("mask not written");
	// legal limits land whole, refused ones leave the old value
	chk_hb_thr_take: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		wr && paddr == hca_pkg::OFS_HB_THR && thr_ok(pwdata)
		|=> cfg.hb_thr == $past(pwdata[hca_pkg::CUR_W-1:0]))
		else $error("legal burnout limit lost");
	chk_hb_thr_drop: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		wr && paddr == hca_pkg::OFS_HB_THR && !thr_ok(pwdata)
		|=> $stable(cfg.hb_thr))
		else $error("illegal burnout limit taken");
	chk_sw_thr_take: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		wr && paddr == hca_pkg::OFS_SW_THR && thr_ok(pwdata)
		|=> cfg.sw_thr == $past(pwdata[hca_pkg::CUR_W-1:0]))
		else $error("legal switch limit lost");
	chk_sw_thr_drop: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		wr && paddr == hca_pkg::OFS_SW_THR && !thr_ok(pwdata)
		|=> $stable(cfg.sw_thr))
		else $error("illegal switch limit taken");
	chk_rd_hb_thr: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		psel && !penable && !pwrite && paddr == hca_pkg::OFS_HB_THR
		|=> prdata[hca_pkg::CUR_W-1:0] == $past(cfg.hb_thr))
		else $error("burnout limit read wrong");
	chk_rd_alarm: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		psel && !penable && !pwrite && paddr == hca_pkg::OFS_ALARM
		|=> prdata[1:0] == $past(hb_vec) && prdata[3:2] == $past(sw_vec))
		else $error("alarm register read wrong");
	// an event in the clear cycle must still leave its bit set
	chk_hb_ev_sets: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		ev[hca_pkg::IRQ_HB_BIT] |=> istat[hca_pkg::IRQ_HB_BIT])
		else $error("burnout event lost");
	chk_sw_ev_sets: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		ev[hca_pkg::IRQ_SW_BIT] |=> istat[hca_pkg::IRQ_SW_BIT])
		else $error("switch event lost");
	chk_w1c_clears: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		wr && paddr == hca_pkg::OFS_ISTAT && pwdata[0] && !ev[0]
		|=> !istat[0])
		else $error("status bit not cleared");
	chk_sw_follow: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		$rose(sw_vec[0]) |=> solid_state_switch_fail)
		else $error("switch pin did not follow channel");
	chk_pin_cause: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		burnout_alarm |-> $past(hb_vec) != '0)
		else $error("burnout pin without channel alarm");
	chk_off_quiet: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		!$past(cfg.enable) |-> hb_vec == '0 && sw_vec == '0)
		else $error("alarm held while disabled");
	chk_long_min: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		!cfg.short_period |-> min_on == CNT_W'(MIN_ON_CYC)
		                   && min_off == CNT_W'(MIN_OFF_CYC))
		else $error("normal period minimum not selected");
endmodule
`default_nettype wire
